// [hdl/cafm_core.sv]
// Acceptance filtering, flag and interrupt logic, configuration lock and mode control.
`timescale 1ns/10ps
`default_nettype none

module cafm_core (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Mode inputs from the CPU and the rest of the controller.
  input  wire logic                 cpu_stop,
  input  wire logic                 cpu_wait,
  input  wire logic                 stop_in_wait,
  input  wire logic                 sleep_ack,
  input  wire logic                 soft_reset_lock,
  // Configuration write and read port.
  input  wire logic                 cfg_wr_en,
  input  wire logic [4:0]           cfg_wr_sel,
  input  wire logic [7:0]           cfg_wr_data,
  input  wire logic [4:0]           cfg_rd_sel,
  output logic      [7:0]           cfg_rd_data_r,
  // Flag clear writes and interrupt enables.
  input  wire logic                 rx_flag_wr,
  input  wire logic [7:0]           rx_flag_wr_data,
  input  wire logic                 tx_flag_wr,
  input  wire logic [2:0]           tx_flag_wr_data,
  input  wire logic [7:0]           rx_irq_enables,
  input  wire logic [2:0]           tx_irq_enables,
  // Received frame from the receive engine.
  input  wire logic                 frame_done,
  input  wire logic [28:0]          frame_id,
  input  wire logic                 frame_ide,
  input  wire logic                 frame_rtr,
  input  wire logic                 frame_srr,
  // Error counters and transmit buffer events.
  input  wire logic [7:0]           rx_err_cnt,
  input  wire logic [8:0]           tx_err_cnt,
  input  wire logic [2:0]           tx_buf_done,
  // Bus pins and the transmit bit of the engine.
  input  wire logic                 can_receive_pin,
  input  wire logic                 tx_bit,
  output logic                      can_transmit_pin,
  // Status, configuration and control outputs.
  output logic      [7:0]           rx_flag_reg,
  output logic      [2:0]           tx_flag_reg,
  output logic      [2:0]           filter_hit_index,
  output logic      [7:0]           module_control_b,
  output logic      [7:0]           bit_timing_a,
  output logic      [7:0]           bit_timing_b,
  output logic      [2:0]           tx_schedule,
  output logic                      rx_fg_load,
  output logic                      rx_bg_keep,
  output logic                      irq_wake,
  output logic                      irq_error,
  output logic                      irq_rx,
  output logic                      irq_tx,
  output cafm_pkg::cafm_mode_t      mode,
  output logic                      core_clk_run,
  output logic                      reg_clk_run,
  output logic                      abort_activity
);

  // All state of the core in one record.
  typedef struct packed {
    logic [1:0]           rx_sync;       // Two-stage receive pin synchroniser.
    cafm_pkg::cafm_mode_t mode;          // Current operating mode.
    logic [7:0]           ctrl_b;        // Second module control register.
    logic [7:0]           timing_a;      // First bit timing register.
    logic [7:0]           timing_b;      // Second bit timing register.
    logic [1:0]           fmode;         // Filter mode field of the filter control register.
    logic [63:0]          pattern;       // Eight acceptance pattern bytes.
    logic [63:0]          mask;          // Eight acceptance mask bytes.
    logic [7:0]           rflags;        // Receive flag register.
    logic [2:0]           tflags;        // Transmit empty flags.
    logic [2:0]           hit_idx;       // Hit index of the foreground message.
    logic                 bg_full;       // Background buffer holds an accepted message.
    logic [2:0]           bg_hit_idx;    // Hit index of the background message.
    logic [2:0]           tx_sched;      // Schedule pulses for transmit buffers.
    logic                 fg_load;       // Pulse: copy a message into the foreground buffer.
    logic                 bg_keep;       // Pulse: keep the new message in the background.
    logic [7:0]           rd_data;       // Registered read data.
    logic                 tx_pin;        // Transmit pin level.
    logic                 irq_wake;      // Wake vector request.
    logic                 irq_err;       // Error vector request.
    logic                 irq_rx;        // Receive vector request.
    logic                 irq_tx;        // Transmit vector request.
    logic                 clk_run;       // Enable for the protocol clocks.
    logic                 reg_run;       // Enable for the register access clocks.
    logic                 abort;         // Abort level for power-down.
  } cafm_core_state_t;

  cafm_core_state_t st_r;    // Registered state.
  cafm_core_state_t st_nxt;  // Next state.

  logic [7:0] hit_vec;       // Filter hits for the current frame.
  logic       any_hit;       // At least one filter matched.
  logic [2:0] low_hit;       // Lowest numbered matching filter.
  logic [7:0] cond;          // Conditions that hold flags set.
  logic [7:0] rset;          // Set events for receive flags.
  logic [7:0] rclr;          // Accepted clear requests for receive flags.
  logic [7:0] rx_en;         // Enables applied to receive flags.
  logic       pd;            // Power-down is the next mode.
  logic       wr_ok;         // Configuration write passes the lock.
  logic       acc_ok;        // Register access permitted.
  logic       accept;        // An accepted frame finished this cycle.

  // Filter bank comparing the frame against the pattern and mask bytes.
  cafm_filter u_filter (
    .pattern   (st_r.pattern),
    .mask      (st_r.mask),
    .fmode     (st_r.fmode),
    .frame_id  (frame_id),
    .frame_ide (frame_ide),
    .frame_rtr (frame_rtr),
    .frame_srr (frame_srr),
    .hit_vec   (hit_vec)
  );

  // Pick the lowest numbered hit so overlapping filters report consistently.
  always_comb begin
    low_hit = 3'h0;
    // Scanning down, the lowest hit lands last.
    for (int k = 7; k >= 0; k--) begin
      if (hit_vec[k]) begin
        low_hit = 3'(k);
      end
    end
    any_hit = |hit_vec;
  end

  // Level conditions from the error counters; the counters are only read here.
  always_comb begin
    cond = 8'h00;
    // Widened to nine bits.
    cond[cafm_pkg::FLG_RX_WARN] = ({1'b0, rx_err_cnt} >= cafm_pkg::WARN_LIMIT);
    cond[cafm_pkg::FLG_TX_WARN] = (tx_err_cnt >= cafm_pkg::WARN_LIMIT);
    cond[cafm_pkg::FLG_RX_PASS] = ({1'b0, rx_err_cnt} > cafm_pkg::PASSIVE_LIMIT);
    cond[cafm_pkg::FLG_TX_PASS] = (tx_err_cnt > cafm_pkg::PASSIVE_LIMIT);
    cond[cafm_pkg::FLG_BUSOFF]  = (tx_err_cnt > cafm_pkg::BUSOFF_LIMIT);
  end

  // Main next-state process.
  always_comb begin
    st_nxt = st_r;

    // The pin is only read through the second stage of the synchroniser.
    st_nxt.rx_sync = {st_r.rx_sync[0], can_receive_pin};

    // Power-down wins over the lock bits; wait without stop-in-wait falls through to the lock bits.
    if (cpu_stop || (cpu_wait && stop_in_wait)) begin
      st_nxt.mode = cafm_pkg::CAFM_MODE_POWER_DOWN;
    end else if (sleep_ack && !soft_reset_lock) begin
      st_nxt.mode = cafm_pkg::CAFM_MODE_SLEEP;
    end else if (!sleep_ack && soft_reset_lock) begin
      st_nxt.mode = cafm_pkg::CAFM_MODE_SOFT_RESET;
    end else begin
      st_nxt.mode = cafm_pkg::CAFM_MODE_NORMAL;
    end
    pd = (st_nxt.mode == cafm_pkg::CAFM_MODE_POWER_DOWN);

    // Clock enables follow the mode.
    st_nxt.clk_run = (st_nxt.mode == cafm_pkg::CAFM_MODE_NORMAL);
    st_nxt.reg_run = !pd;

    st_nxt.abort   = pd;

    // The pin is forced recessive in every low-power mode.
    st_nxt.tx_pin = st_nxt.clk_run ? tx_bit : 1'b1;

    // Accesses are refused in power-down; configuration also needs the lock.
    // Gated by the mode flop, a cycle late.
    acc_ok = (st_r.mode != cafm_pkg::CAFM_MODE_POWER_DOWN);
    wr_ok  = cfg_wr_en && acc_ok && soft_reset_lock;

    // Configuration writes.
    if (wr_ok) begin
      case (cfg_wr_sel)
        cafm_pkg::SEL_CTRL_B: begin
          st_nxt.ctrl_b = cfg_wr_data;
        end
        cafm_pkg::SEL_TIMING_A: begin
          st_nxt.timing_a = cfg_wr_data;
        end
        cafm_pkg::SEL_TIMING_B: begin
          st_nxt.timing_b = cfg_wr_data;
        end
        cafm_pkg::SEL_FILTER_CTRL: begin
          st_nxt.fmode = cfg_wr_data[cafm_pkg::FMODE_POS +: 2];
        end
        default: begin
          // Pattern and mask bytes sit in two blocks of eight selects.
          if (cfg_wr_sel[4:3] == cafm_pkg::SEL_PATTERN[4:3]) begin
            st_nxt.pattern[8*cfg_wr_sel[2:0] +: 8] = cfg_wr_data;
          end else if (cfg_wr_sel[4:3] == cafm_pkg::SEL_MASK[4:3]) begin
            st_nxt.mask[8*cfg_wr_sel[2:0] +: 8] = cfg_wr_data;
          end
        end
      endcase
    end

    // Read data; nothing is returned while powered down.
    // Unmapped selects read as zero.
    st_nxt.rd_data = 8'h00;
    if (acc_ok) begin
      case (cfg_rd_sel)
        cafm_pkg::SEL_CTRL_B: begin
          st_nxt.rd_data = st_r.ctrl_b;
        end
        cafm_pkg::SEL_TIMING_A: begin
          st_nxt.rd_data = st_r.timing_a;
        end
        cafm_pkg::SEL_TIMING_B: begin
          st_nxt.rd_data = st_r.timing_b;
        end
        cafm_pkg::SEL_FILTER_CTRL: begin
          st_nxt.rd_data = {2'h0, st_r.fmode, 1'b0, st_r.hit_idx};
        end
        default: begin
          if (cfg_rd_sel[4:3] == cafm_pkg::SEL_PATTERN[4:3]) begin
            st_nxt.rd_data = st_r.pattern[8*cfg_rd_sel[2:0] +: 8];
          end else if (cfg_rd_sel[4:3] == cafm_pkg::SEL_MASK[4:3]) begin
            st_nxt.rd_data = st_r.mask[8*cfg_rd_sel[2:0] +: 8];
          end
        end
      endcase
    end

    // Receive side: only a running controller accepts or copies messages.
    accept           = frame_done && any_hit && st_r.clk_run;
    st_nxt.fg_load   = 1'b0;
    st_nxt.bg_keep   = 1'b0;
    rset             = 8'h00;
    rset[cafm_pkg::FLG_RX_WARN] = cond[cafm_pkg::FLG_RX_WARN];
    rset[cafm_pkg::FLG_TX_WARN] = cond[cafm_pkg::FLG_TX_WARN];
    rset[cafm_pkg::FLG_RX_PASS] = cond[cafm_pkg::FLG_RX_PASS];
    rset[cafm_pkg::FLG_TX_PASS] = cond[cafm_pkg::FLG_TX_PASS];
    rset[cafm_pkg::FLG_BUSOFF]  = cond[cafm_pkg::FLG_BUSOFF];

    // Dominant bus level during sleep wakes the controller when allowed.
    rset[cafm_pkg::FLG_WAKE] = !st_r.rx_sync[1] && sleep_ack
                               && rx_irq_enables[cafm_pkg::FLG_WAKE] && !pd;

    // Clearing is a write of one; conditions that still hold keep the flag.
    rclr = (rx_flag_wr && acc_ok) ? rx_flag_wr_data : 8'h00;

    if (accept && !st_r.rflags[cafm_pkg::FLG_RXF]) begin
      // Free foreground buffer: load it directly.
      rset[cafm_pkg::FLG_RXF] = 1'b1;
      st_nxt.hit_idx = low_hit;
      st_nxt.fg_load = 1'b1;
    end else if (accept && !st_r.bg_full) begin
      // Foreground busy: the message waits in the background buffer.
      st_nxt.bg_full    = 1'b1;
      st_nxt.bg_hit_idx = low_hit;
      st_nxt.bg_keep    = 1'b1;
    end else if (accept) begin
      // Both buffers busy: the newest message is dropped.
      rset[cafm_pkg::FLG_OVERRUN] = 1'b1;
    end else if (st_r.bg_full && !st_r.rflags[cafm_pkg::FLG_RXF] && st_r.clk_run) begin
      // Foreground released: move the waiting message forward.
      rset[cafm_pkg::FLG_RXF] = 1'b1;
      st_nxt.hit_idx = st_r.bg_hit_idx;
      st_nxt.bg_full = 1'b0;
      st_nxt.fg_load = 1'b1;
    end

    // Set wins over clear, and the error conditions block their clears.
    st_nxt.rflags = (st_r.rflags & ~rclr) | rset;

    // Transmit empty flags: a clear schedules the buffer, a done event sets it.
    st_nxt.tx_sched = (tx_flag_wr && acc_ok) ? (tx_flag_wr_data & st_r.tflags) : 3'h0;
    st_nxt.tflags   = (st_r.tflags & ~st_nxt.tx_sched) | tx_buf_done;

    // Each request stands while any enabled flag of its vector is set; the wake request also needs sleep_ack.
    rx_en = st_nxt.rflags & rx_irq_enables;
    st_nxt.irq_wake = rx_en[cafm_pkg::FLG_WAKE] && sleep_ack;
    st_nxt.irq_err  = |rx_en[cafm_pkg::FLG_RX_WARN:cafm_pkg::FLG_OVERRUN];
    st_nxt.irq_rx   = rx_en[cafm_pkg::FLG_RXF];
    st_nxt.irq_tx   = |(st_nxt.tflags & tx_irq_enables);

    // Power-down stops the buffer and schedule pulses immediately.
    // Flags keep their values; only pulses are masked.
    if (pd) begin
      st_nxt.fg_load  = 1'b0;
      st_nxt.bg_keep  = 1'b0;
      st_nxt.tx_sched = 3'h0;
    end
  end

  // State register; every field takes a constant under reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Fields not named below reset to zero.
      st_r            <= '0;
      st_r.rx_sync    <= 2'h3;
      st_r.mode       <= cafm_pkg::CAFM_MODE_NORMAL;
      st_r.ctrl_b     <= cafm_pkg::CFG_RESET;
      st_r.timing_a   <= cafm_pkg::CFG_RESET;
      st_r.timing_b   <= cafm_pkg::CFG_RESET;
      st_r.fmode      <= cafm_pkg::FMODE_32;
      st_r.rflags     <= cafm_pkg::FLAG_RESET;
      st_r.tflags     <= cafm_pkg::TXE_RESET;
      st_r.tx_pin     <= 1'b1;
      st_r.clk_run    <= 1'b1;
      st_r.reg_run    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign cfg_rd_data_r    = st_r.rd_data;

  // Transmit pin.
  assign can_transmit_pin = st_r.tx_pin;

  // Status flags and hit index.
  assign rx_flag_reg      = st_r.rflags;
  assign tx_flag_reg      = st_r.tflags;
  assign filter_hit_index = st_r.hit_idx;

  // Configuration registers.
  assign module_control_b = st_r.ctrl_b;
  assign bit_timing_a     = st_r.timing_a;
  assign bit_timing_b     = st_r.timing_b;

  // Buffer pulses.
  assign tx_schedule      = st_r.tx_sched;
  assign rx_fg_load       = st_r.fg_load;
  assign rx_bg_keep       = st_r.bg_keep;

  // Interrupt requests.
  assign irq_wake         = st_r.irq_wake;
  assign irq_error        = st_r.irq_err;
  assign irq_rx           = st_r.irq_rx;
  assign irq_tx           = st_r.irq_tx;

  // Mode, clock enables and abort.
  assign mode             = st_r.mode;
  assign core_clk_run     = st_r.clk_run;
  assign reg_clk_run      = st_r.reg_run;
  assign abort_activity   = st_r.abort;

endmodule

`default_nettype wire

// [hdl/cafm_pkg.sv]
// Package with constants and types shared by the acceptance filter and its control core.
//
// Overview of operation
// - 32-bit mode: two filters, full identifier.
// - 16-bit mode: four filters, short identifiers.
// - 8-bit mode: eight filters, first byte.
// - Closed mode never accepts any frame.
// - Pattern bit required, set mask ignores it.
// - Acceptance sets full flag, lowest hit reported.
// - Receive interrupt right after accepted frame end.
// - Transmit interrupt while any buffer empty.
// - Wake interrupt needs sleep acknowledge and enable.
// - Warning flags when error counter reaches 96.
// - Passive flags when counter exceeds 127.
// - Bus-off flag when transmit counter exceeds 255.
// - Eleven sources, local enables, four vectors.
// - Third accepted frame is overrun and dropped.
// - Request holds while enabled flag is set.
// - Write one clears; held condition blocks clear.
// - Error counters have no write path.
// - Configuration writes need the soft-reset lock.
// - Transmit pin recessive in low-power modes.
// - Sleep/soft reset keep register clocks only.
// - Mode chosen from CPU state and lock bits.
// - CPU wait without stop-in-wait follows lock bits.
// - Power-down aborts activity, denies register access.
package cafm_pkg;

  // Operating modes of the controller.
  typedef enum logic [1:0] {
    CAFM_MODE_NORMAL,
    CAFM_MODE_SLEEP,
    CAFM_MODE_SOFT_RESET,
    CAFM_MODE_POWER_DOWN
  } cafm_mode_t;

  // Filter mode encodings held in the filter control register.
  localparam logic [1:0] FMODE_32     = 2'h0;
  localparam logic [1:0] FMODE_16     = 2'h1;
  localparam logic [1:0] FMODE_8      = 2'h2;
  localparam logic [1:0] FMODE_CLOSED = 2'h3;
  localparam int         FMODE_POS    = 4;

  // Register selects used on the configuration port.
  localparam logic [4:0] SEL_CTRL_B      = 5'h00;
  localparam logic [4:0] SEL_TIMING_A    = 5'h01;
  localparam logic [4:0] SEL_TIMING_B    = 5'h02;
  localparam logic [4:0] SEL_FILTER_CTRL = 5'h03;
  localparam logic [4:0] SEL_PATTERN     = 5'h08;
  localparam logic [4:0] SEL_MASK        = 5'h10;

  // Bit positions inside the receive flag register.
  localparam int FLG_RXF     = 0;
  localparam int FLG_OVERRUN = 1;
  localparam int FLG_BUSOFF  = 2;
  localparam int FLG_TX_PASS = 3;
  localparam int FLG_RX_PASS = 4;
  localparam int FLG_TX_WARN = 5;
  localparam int FLG_RX_WARN = 6;
  localparam int FLG_WAKE    = 7;

  // Error counter limits.
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0ff;

  // Values after reset.
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] FLAG_RESET  = 8'h00;
  localparam logic [2:0] TXE_RESET   = 3'h7;

endpackage

// [hdl/cafm_filter.sv]
// Identifier acceptance filter bank with 32, 16 and 8 bit compare modes.
`timescale 1ns/10ps
`default_nettype none

module cafm_filter (
  input  wire logic [63:0] pattern,
  input  wire logic [63:0] mask,
  input  wire logic [1:0]  fmode,
  input  wire logic [28:0] frame_id,
  input  wire logic        frame_ide,
  input  wire logic        frame_rtr,
  input  wire logic        frame_srr,
  output logic      [7:0]  hit_vec
);

  logic [31:0] word;   // Frame fields arranged as the 32-bit compare word.
  logic [7:0]  m32;    // Byte i matched against word byte i mod 4.
  logic [7:0]  m16;    // Byte i matched against word byte i mod 2.
  logic [7:0]  m8;     // Byte i matched against the first word byte.

  // Extended frames fill all four bytes; standard frames use the first two.
  always_comb begin
    if (frame_ide) begin
      word = {frame_id[28:21], frame_id[20:18], frame_srr, frame_ide, frame_id[17:15],
              frame_id[14:7], frame_id[6:0], frame_rtr};
    end else begin
      word = {frame_id[10:3], frame_id[2:0], frame_rtr, frame_ide, 3'h0, 16'h0000};
    end
  end

  // Each pattern byte is compared in all three alignments; mask ones are don't-care.
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_byte
      assign m32[i] = &(~(word[31-8*(i%4) -: 8] ^ pattern[8*i +: 8]) | mask[8*i +: 8]);
      assign m16[i] = &(~(word[31-8*(i%2) -: 8] ^ pattern[8*i +: 8]) | mask[8*i +: 8]);
      assign m8[i]  = &(~(word[31:24] ^ pattern[8*i +: 8]) | mask[8*i +: 8]);
    end
  endgenerate

  // Combine byte matches into the filter hits of the selected mode.
  always_comb begin
    hit_vec = 8'h00;
    case (fmode)
      cafm_pkg::FMODE_32: begin
        hit_vec = {6'h00, &m32[7:4], &m32[3:0]};
      end
      cafm_pkg::FMODE_16: begin
        hit_vec = {4'h0, &m16[7:6], &m16[5:4], &m16[3:2], &m16[1:0]};
      end
      cafm_pkg::FMODE_8: begin
        hit_vec = m8;
      end
      default: begin
        hit_vec = 8'h00;
      end
    endcase
  end

endmodule

`default_nettype wire

// [bench/cafm_core_asserts.sv]
// Port-level checker for the acceptance filter and control core.
`timescale 1ns/10ps
`default_nettype none
module cafm_core_asserts (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 cpu_stop,
  input wire logic                 cpu_wait,
  input wire logic                 stop_in_wait,
  input wire logic                 sleep_ack,
  input wire logic                 soft_reset_lock,
  input wire logic                 cfg_wr_en,
  input wire logic [4:0]           cfg_wr_sel,
  input wire logic [7:0]           rx_err_cnt,
  input wire logic [8:0]           tx_err_cnt,
  input wire logic [2:0]           tx_irq_enables,
  input wire logic                 can_transmit_pin,
  input wire logic [7:0]           rx_flag_reg,
  input wire logic [2:0]           tx_flag_reg,
  input wire logic [7:0]           bit_timing_a,
  input wire logic                 rx_fg_load,
  input wire logic                 irq_tx,
  input wire cafm_pkg::cafm_mode_t mode,
  input wire logic                 core_clk_run,
  input wire logic                 reg_clk_run,
  input wire logic                 abort_activity
);
  // All checks share the core clock and its reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  localparam cafm_pkg::cafm_mode_t NRM = cafm_pkg::CAFM_MODE_NORMAL;
  localparam cafm_pkg::cafm_mode_t PWD = cafm_pkg::CAFM_MODE_POWER_DOWN;
  pin_recessive_a: assert property ((mode != NRM) [*2] |-> can_transmit_pin) else $error("pin not recessive");
  stop_power_a: assert property (cpu_stop |=> mode == PWD) else $error("stop without power-down");
  wait_normal_a: assert property (cpu_wait && !stop_in_wait && !cpu_stop && !sleep_ack && !soft_reset_lock
    |=> mode == NRM) else $error("wait left normal mode");
  abort_pd_a: assert property (abort_activity == (mode == PWD)) else $error("abort mismatch");
  clk_stop_a: assert property ((mode == PWD) [*2] |-> !reg_clk_run && !core_clk_run) else $error("clock runs");
  rx_warn_a: assert property (mode == NRM && rx_err_cnt >= 8'h60 |=> rx_flag_reg[6]) else $error("no warning");
  bus_off_a: assert property (mode == NRM && tx_err_cnt > 9'h0ff |=> rx_flag_reg[2]) else $error("no bus-off");
  tx_irq_a: assert property ($past(rst_n) && $stable(tx_flag_reg) && $stable(tx_irq_enables)
    |-> irq_tx == |(tx_flag_reg & tx_irq_enables)) else $error("transmit request wrong");
  cfg_lock_a: assert property (cfg_wr_en && !soft_reset_lock && cfg_wr_sel == cafm_pkg::SEL_TIMING_A
    |=> $stable(bit_timing_a)) else $error("locked write landed");
  load_full_a: assert property (rx_fg_load |-> rx_flag_reg[0]) else $error("load without full flag");
  cover property (rx_fg_load);
  cover property (mode == PWD);
  cover property (irq_tx ##1 !irq_tx);
endmodule
bind cafm_core cafm_core_asserts i_cafm_core_asserts (.*);
`default_nettype wire

// [bench/cafm_bus_model.sv]
// Bus-side model: what the transceiver hands to the receive pin.
`timescale 1ns/10ps
`default_nettype none
module cafm_bus_model (
  input  wire logic dominant,
  output wire logic can_receive_pin
);
  // The bus rests recessive (high) unless a remote node drives dominant.
  assign can_receive_pin = !dominant;
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the acceptance filter and control core.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic core_clk, rst_n, cpu_stop, cpu_wait, stop_in_wait, sleep_ack, soft_reset_lock, cfg_wr_en, rx_flag_wr;
  logic tx_flag_wr, frame_done, frame_ide, frame_rtr, frame_srr, tx_bit, dominant, can_transmit_pin, rx_fg_load;
  logic rx_bg_keep, irq_wake, irq_error, irq_rx, irq_tx, core_clk_run, reg_clk_run, abort_activity;
  logic [4:0] cfg_wr_sel, cfg_rd_sel;
  logic [7:0] cfg_wr_data, rx_flag_wr_data, rx_irq_enables, rx_err_cnt, cfg_rd_data_r, rx_flag_reg;
  logic [7:0] module_control_b, bit_timing_a, bit_timing_b;
  logic [2:0] tx_flag_wr_data, tx_irq_enables, tx_buf_done, tx_flag_reg, filter_hit_index, tx_schedule;
  logic [8:0] tx_err_cnt;
  logic [28:0] frame_id;
  wire can_receive_pin;
  cafm_pkg::cafm_mode_t mode;
  int mismatches = 0, n_checks = 0, cycles = 0;
  cafm_core i_cafm_core (.*);
  cafm_bus_model i_cafm_bus_model (.dominant(dominant), .can_receive_pin(can_receive_pin));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(int n = 1); repeat (n) @(negedge core_clk); endtask
  // One configuration write pulse; the caller owns the lock.
  task automatic wr(logic [4:0] s, logic [7:0] d);
    cfg_wr_sel = s; cfg_wr_data = d; cfg_wr_en = 1; step(); cfg_wr_en = 0; step();
  endtask
  task automatic cfg(logic [4:0] s, logic [7:0] d);
    soft_reset_lock = 1; step(2); wr(s, d); soft_reset_lock = 0; step(2);
  endtask
  task automatic frame(); step(); frame_done = 1; step(); frame_done = 0; endtask
  // Flags are cleared by plain writes of only the bits serviced.
  task automatic clr(logic [7:0] d); rx_flag_wr_data = d; rx_flag_wr = 1; step(); rx_flag_wr = 0; step(); endtask
  task automatic t_filter();
    cfg(cafm_pkg::SEL_FILTER_CTRL, 8'h20);
    for (int b = 0; b < 8; b++) cfg(5'(cafm_pkg::SEL_PATTERN + b), (b == 3 || b == 5) ? 8'h5a : 8'ha5);
    frame_id = {8'h5a, 21'h0};
    frame(); `CHK("full", 1'h1, rx_flag_reg[0])
    `CHK("hit", 3'h3, filter_hit_index)
    `CHK("rx irq", 1'h1, irq_rx)
    frame(); `CHK("bg keep", 1'h1, rx_bg_keep)
    frame(); step(); `CHK("overrun", 1'h1, rx_flag_reg[1])
    clr(8'h03); clr(8'h01); `CHK("emptied", 2'h0, rx_flag_reg[1:0])
    cfg(5'(cafm_pkg::SEL_MASK + 1), 8'hff); frame(); `CHK("mask hit", 3'h1, filter_hit_index)
    clr(8'h01); cfg(5'(cafm_pkg::SEL_PATTERN + 4), 8'h5a); cfg(5'(cafm_pkg::SEL_PATTERN + 5), 8'h08);
    cfg(cafm_pkg::SEL_FILTER_CTRL, 8'h10); frame(); `CHK("hit16", 3'h2, filter_hit_index)
    clr(8'h01); cfg(cafm_pkg::SEL_FILTER_CTRL, 8'h30); frame(); step(); `CHK("closed", 1'h0, rx_flag_reg[0])
    cfg(5'(cafm_pkg::SEL_MASK + 6), 8'hff); cfg(5'(cafm_pkg::SEL_MASK + 7), 8'hff);
    cfg(cafm_pkg::SEL_FILTER_CTRL, 8'h00); frame(); `CHK("hit32", 3'h1, filter_hit_index)
  endtask
  task automatic t_err();
    rx_irq_enables = 8'h7e; rx_err_cnt = 8'h60; step(2);
    `CHK("rx warn", 1'h1, rx_flag_reg[6])
    `CHK("err irq", 1'h1, irq_error)
    clr(8'h40); `CHK("held", 1'h1, rx_flag_reg[6])
    rx_err_cnt = 8'h7f; step(2); `CHK("not passive", 1'h0, rx_flag_reg[4])
    rx_err_cnt = 8'h5f; step(); clr(8'h40); `CHK("cleared", 1'h0, rx_flag_reg[6])
    `CHK("err irq off", 1'h0, irq_error)
    rx_err_cnt = 8'h80; tx_err_cnt = 9'h100; step(2);
    `CHK("passive", 1'h1, rx_flag_reg[4])
    `CHK("bus off", 1'h1, rx_flag_reg[2])
    rx_err_cnt = 8'h00; tx_err_cnt = 9'h000; step(); clr(8'h7e);
  endtask
  task automatic t_tx();
    tx_irq_enables = 3'h1; step(2); `CHK("tx irq", 1'h1, irq_tx)
    tx_flag_wr_data = 3'h1; tx_flag_wr = 1; step(); tx_flag_wr = 0;
    `CHK("schedule", 3'h1, tx_schedule)
    step(); `CHK("tx flags", 3'h6, tx_flag_reg)
    `CHK("tx irq off", 1'h0, irq_tx)
    tx_buf_done = 3'h1; step(); tx_buf_done = 0; step(); `CHK("tx irq back", 1'h1, irq_tx)
  endtask
  // Each row: stop, wait, stop-in-wait, sleep acknowledge, lock, expected mode.
  task automatic t_modes();
    logic [6:0] tbl [5] = '{7'h43, 7'h33, 7'h09, 7'h06, 7'h20};
    wr(cafm_pkg::SEL_TIMING_A, 8'h3c); `CHK("locked", 8'h00, bit_timing_a)
    cfg(cafm_pkg::SEL_TIMING_A, 8'h3c); `CHK("unlocked", 8'h3c, bit_timing_a)
    cfg(cafm_pkg::SEL_CTRL_B, 8'h5c); `CHK("ctrl b", 8'h5c, module_control_b)
    cfg_rd_sel = cafm_pkg::SEL_TIMING_A; step(); `CHK("read", 8'h3c, cfg_rd_data_r)
    for (int i = 0; i < 5; i++) begin
      {cpu_stop, cpu_wait, stop_in_wait, sleep_ack, soft_reset_lock} = tbl[i][6:2];
      step(3); `CHK("mode", tbl[i][1:0], mode)
      `CHK("pin", tbl[i][1:0] != 2'h0, can_transmit_pin)
      `CHK("reg clk", tbl[i][1:0] != 2'h3, reg_clk_run)
    end
    cpu_wait = 0; cpu_stop = 1; soft_reset_lock = 1; step(2); wr(cafm_pkg::SEL_TIMING_B, 8'h11);
    `CHK("pd write", 8'h00, bit_timing_b)
    `CHK("abort", 1'h1, abort_activity)
    `CHK("pd read", 8'h00, cfg_rd_data_r)
    cpu_stop = 0; soft_reset_lock = 0; step(2);
  endtask
  task automatic t_wake();
    rx_irq_enables = 8'h81; sleep_ack = 1; step(2); dominant = 1; step(5); dominant = 0;
    `CHK("wake", 1'h1, rx_flag_reg[7])
    `CHK("wake irq", 1'h1, irq_wake)
    sleep_ack = 0; step(2); `CHK("wake irq off", 1'h0, irq_wake)
  endtask
  initial begin
    {cpu_stop, cpu_wait, stop_in_wait, sleep_ack, soft_reset_lock, cfg_wr_en, rx_flag_wr, tx_flag_wr} = '0;
    {frame_done, frame_rtr, frame_srr, tx_bit, dominant, cfg_wr_sel, cfg_rd_sel, cfg_wr_data} = '0;
    {rx_flag_wr_data, rx_err_cnt, tx_flag_wr_data, tx_buf_done, tx_err_cnt, frame_id} = '0;
    frame_ide = 1; rx_irq_enables = 8'h01; tx_irq_enables = 3'h0; rst_n = 0;
    step(5); rst_n = 1; step();
    t_filter(); t_err(); t_tx(); t_modes(); t_wake();
    complete_run();
  end
endmodule
`default_nettype wire
